// ### prg_pkg.sv
// Constants and carrier types for the peripheral reset and gating block
package prg_pkg;

	localparam int ADDR_W = 12;

	// Register byte offsets
	localparam logic [11:0] OFF_SOFT_RESET_A  = 12'h040;
	localparam logic [11:0] OFF_SOFT_RESET_B  = 12'h044;
	localparam logic [11:0] OFF_SOFT_RESET_C  = 12'h048;
	localparam logic [11:0] OFF_DEEP_GATE     = 12'h128;
	localparam logic [11:0] OFF_MODE_CTRL     = 12'h200;
	localparam logic [11:0] OFF_IRQ_STATUS    = 12'h204;
	localparam logic [11:0] OFF_IRQ_MASK      = 12'h208;
	localparam logic [11:0] OFF_FAULT_ADDR    = 12'h20C;

	// Writable fields
	localparam logic [31:0] SOFT_A_FIELDS = 32'h0001_0008;
	localparam logic [31:0] SOFT_B_FIELDS = 32'h0007_1013;
	localparam logic [31:0] SOFT_C_FIELDS = 32'h0000_001F;
	localparam logic [31:0] GATE_FIELDS   = 32'h0000_001F;

	// Reset values
	localparam logic [31:0] SOFT_RESET_RST = 32'h0000_0000;
	localparam logic [31:0] GATE_RST       = 32'h0000_0000;

	localparam int NUM_PORTS = 5;

	// Interrupt status bit positions
	localparam int IRQ_FAULT_POS = 0;
	localparam int IRQ_SOFT_POS  = 1;
	localparam int IRQ_W         = 2;

	// Peripheral access sideband from the system bus fabric
	typedef struct packed {
		logic       valid;
		logic [3:0] target;
	} periph_req_t;

	// Target codes carried in periph_req_t.target
	localparam logic [3:0] TGT_PORT_A = 4'h0;

	typedef struct packed {
		logic [12:0] periphRst;
		logic [4:0]  portRst;
	} reset_bus_t;

endpackage

// ### peripheral_reset_and_gating.sv
// Software reset control and deep-sleep port clock gating with APB access
`timescale 1ns/10ps
// Overview of operation
// - In deep sleep, gate bit set clocks its port; clear leaves it unclocked.
// - Access to a gated-off peripheral answers with a bus fault.
// - Reset register writes only change bits allowed by the capability mask.
// - Third register: ports E..A at bits 4..0; bits 31..5 read zero.
// - All reset registers clear to zero on system reset.
module peripheral_reset_and_gating
	import prg_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [31:0]       capabilityMaskA,
	input  wire logic [31:0]       capabilityMaskB,
	input  wire logic [31:0]       capabilityMaskD,
	input  wire logic              deepSleep,
	input  wire periph_req_t       periphReq,
	output logic                   periphFault,
	output logic [NUM_PORTS-1:0]   portClockEn,
	output reset_bus_t             resetBus,
	output logic                   irq
);

	logic [31:0]       softResetA_ff;
	logic [31:0]       softResetB_ff;
	logic [31:0]       softResetC_ff;
	logic [31:0]       deepGate_ff;
	logic [NUM_PORTS-1:0] runGate_ff;
	logic [IRQ_W-1:0]  irqStatus_ff;
	logic [IRQ_W-1:0]  irqMask_ff;
	logic [3:0]        faultTarget_ff;
	logic              access;
	logic              wrAccess;
	logic              rdAccess;
	logic              mapped;
	logic              accessFault;
	logic [31:0]       nxt_rdata;
	logic [NUM_PORTS-1:0] nxt_portClk;
	logic              portGated;
	logic              softWriteEvt;

	// Masked write: only implemented and allowed bits change
	function automatic logic [31:0] maskedWrite(
		input logic [31:0] oldVal,
		input logic [31:0] newVal,
		input logic [31:0] allowed
	);
		maskedWrite = (oldVal & ~allowed) | (newVal & allowed);
	endfunction

	// Single-wait-state slave: answer in the access phase
	assign access   = psel & penable;
	assign wrAccess = access & pwrite;
	assign rdAccess = access & ~pwrite;

	always_comb begin
		mapped = 1'b1;
		unique case (paddr)
			OFF_SOFT_RESET_A: nxt_rdata = softResetA_ff;
			OFF_SOFT_RESET_B: nxt_rdata = softResetB_ff;
			OFF_SOFT_RESET_C: nxt_rdata = softResetC_ff;
			OFF_DEEP_GATE:    nxt_rdata = deepGate_ff;
			OFF_MODE_CTRL:    nxt_rdata = {27'h0, runGate_ff};
			OFF_IRQ_STATUS:   nxt_rdata = {30'h0, irqStatus_ff};
			OFF_IRQ_MASK:     nxt_rdata = {30'h0, irqMask_ff};
			OFF_FAULT_ADDR:   nxt_rdata = {28'h0, faultTarget_ff};
			default: begin
				nxt_rdata = 32'h0000_0000;
				mapped    = 1'b0;
			end
		endcase
	end

	// Registered handshake: ready one cycle into the access phase
	always_ff @(posedge clk) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= access & ~pready;
			pslverr <= access & ~pready & ~mapped;
			prdata  <= (rdAccess & ~pready) ? nxt_rdata : 32'h0000_0000;
		end
	end

	logic doWrite;
	assign doWrite = wrAccess & pready;

	always_ff @(posedge clk) begin
		if (rst) begin
			softResetA_ff <= SOFT_RESET_RST;
			softResetB_ff <= SOFT_RESET_RST;
			softResetC_ff <= SOFT_RESET_RST;
		end else if (doWrite) begin
			if (paddr == OFF_SOFT_RESET_A)
				softResetA_ff <= maskedWrite(softResetA_ff, pwdata,
					SOFT_A_FIELDS & capabilityMaskA);
			if (paddr == OFF_SOFT_RESET_B)
				softResetB_ff <= maskedWrite(softResetB_ff, pwdata,
					SOFT_B_FIELDS & capabilityMaskB);
			// five ports, upper bits stay zero
			if (paddr == OFF_SOFT_RESET_C)
				softResetC_ff <= maskedWrite(softResetC_ff, pwdata,
					SOFT_C_FIELDS & capabilityMaskD);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			deepGate_ff <= GATE_RST;
			runGate_ff  <= '1;
		end else if (doWrite) begin
			if (paddr == OFF_DEEP_GATE)
				deepGate_ff <= pwdata & GATE_FIELDS;
			if (paddr == OFF_MODE_CTRL)
				runGate_ff <= pwdata[NUM_PORTS-1:0];
		end
	end

	// deep-sleep gating picks the deep-sleep bits
	assign nxt_portClk = deepSleep ? deepGate_ff[NUM_PORTS-1:0] : runGate_ff;

	always_ff @(posedge clk) begin
		if (rst)
			portClockEn <= '0;
		else
			portClockEn <= nxt_portClk;
	end

	// reset held while the bit is set
	always_ff @(posedge clk) begin
		if (rst) begin
			resetBus <= '0;
		end else begin
			resetBus.periphRst <= {softResetA_ff[16], softResetA_ff[3],
				softResetB_ff[18:16], softResetB_ff[12], softResetB_ff[4],
				softResetB_ff[1:0], 4'h0};
			resetBus.portRst   <= softResetC_ff[NUM_PORTS-1:0];
		end
	end

	// access to an unclocked port faults
	assign portGated = (periphReq.target < 4'(NUM_PORTS)) &&
		!nxt_portClk[3'(periphReq.target - TGT_PORT_A)];
	assign accessFault = periphReq.valid & portGated;

	always_ff @(posedge clk) begin
		if (rst) begin
			periphFault    <= 1'b0;
			faultTarget_ff <= 4'h0;
		end else begin
			periphFault <= accessFault;
			if (accessFault)
				faultTarget_ff <= periphReq.target;
		end
	end

	assign softWriteEvt = doWrite && (paddr == OFF_SOFT_RESET_A ||
		paddr == OFF_SOFT_RESET_B || paddr == OFF_SOFT_RESET_C);

	// Set wins over a same-cycle write-one clear
	always_ff @(posedge clk) begin
		if (rst) begin
			irqStatus_ff <= '0;
			irqMask_ff   <= '0;
		end else begin
			irqStatus_ff <= (irqStatus_ff &
				~((doWrite && paddr == OFF_IRQ_STATUS) ? pwdata[IRQ_W-1:0] : '0))
				| {softWriteEvt, accessFault};
			if (doWrite && paddr == OFF_IRQ_MASK)
				irqMask_ff <= pwdata[IRQ_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			irq <= 1'b0;
		else
			irq <= |(irqStatus_ff & irqMask_ff);
	end

	property p_resv_a;
		@(posedge clk) disable iff (rst) (softResetA_ff & ~SOFT_A_FIELDS) == 32'h0;
	endproperty
	a_resv_a: assert property (p_resv_a) else $error("reserved bits set in reg a");

	property p_resv_b;
		@(posedge clk) disable iff (rst) (softResetB_ff & ~SOFT_B_FIELDS) == 32'h0;
	endproperty
	a_resv_b: assert property (p_resv_b) else $error("reserved bits set in reg b");

	property p_resv_c;
		@(posedge clk) disable iff (rst) softResetC_ff[31:5] == 27'h0;
	endproperty
	a_resv_c: assert property (p_resv_c) else $error("reserved bits set in reg c");

	property p_cap_c;
		@(posedge clk) disable iff (rst)
			!$past(doWrite) |-> ((softResetC_ff ^ $past(softResetC_ff)) == 32'h0) ||
			$past(rst);
	endproperty
	a_cap_c: assert property (p_cap_c) else $error("reg c changed without write");

	property p_cap_mask;
		@(posedge clk) disable iff (rst)
			(doWrite && paddr == OFF_SOFT_RESET_C && capabilityMaskD[0] == 1'b0)
			|=> softResetC_ff[0] == $past(softResetC_ff[0]);
	endproperty
	a_cap_mask: assert property (p_cap_mask) else $error("masked bit changed");

	property p_rst_zero;
		@(posedge clk) $past(rst) |-> softResetA_ff == 32'h0 && softResetB_ff == 32'h0
			&& softResetC_ff == 32'h0;
	endproperty
	a_rst_zero: assert property (p_rst_zero) else $error("reset value wrong");

	property p_hold;
		@(posedge clk) disable iff (rst)
			softResetC_ff[2] |=> resetBus.portRst[2];
	endproperty
	a_hold: assert property (p_hold) else $error("port not held in reset");

	property p_deep_gate;
		@(posedge clk) disable iff (rst)
			deepSleep && !deepGate_ff[1] |=> !portClockEn[1];
	endproperty
	a_deep_gate: assert property (p_deep_gate) else $error("gated port clocked");

	property p_fault;
		@(posedge clk) disable iff (rst) accessFault |=> periphFault ##0 irqStatus_ff[0];
	endproperty
	a_fault: assert property (p_fault) else $error("no fault on gated access");

	// Handshake answers are one-cycle pulses
	property p_ready_pulse;
		@(posedge clk) disable iff (rst) pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready held too long");

	property p_err_with_ready;
		@(posedge clk) disable iff (rst) pslverr |-> pready;
	endproperty
	a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");

	// Read data stays zero outside the answer cycle
	property p_rdata_idle;
		@(posedge clk) disable iff (rst) !pready |-> prdata == 32'h0000_0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero when idle");

	property p_resv_gate;
		@(posedge clk) disable iff (rst) deepGate_ff[31:5] == 27'h0;
	endproperty
	a_resv_gate: assert property (p_resv_gate) else $error("reserved gate bits set");

	property p_deep_all;
		@(posedge clk) disable iff (rst)
			deepSleep |=> portClockEn == $past(deepGate_ff[NUM_PORTS-1:0]);
	endproperty
	a_deep_all: assert property (p_deep_all) else $error("deep gate not applied");

	property p_run_all;
		@(posedge clk) disable iff (rst)
			!deepSleep |=> portClockEn == $past(runGate_ff);
	endproperty
	a_run_all: assert property (p_run_all) else $error("run gate not applied");

	property p_gated_fault;
		@(posedge clk) disable iff (rst)
			periphReq.valid && periphReq.target == TGT_PORT_A && !nxt_portClk[0] |=> periphFault;
	endproperty
	a_gated_fault: assert property (p_gated_fault) else $error("port a access not faulted");

	property p_open_no_fault;
		@(posedge clk) disable iff (rst) !accessFault |=> !periphFault;
	endproperty
	a_open_no_fault: assert property (p_open_no_fault) else $error("spurious fault");

	property p_cap_a;
		@(posedge clk) disable iff (rst)
			(doWrite && paddr == OFF_SOFT_RESET_A && capabilityMaskA[16] == 1'b0)
			|=> softResetA_ff[16] == $past(softResetA_ff[16]);
	endproperty
	a_cap_a: assert property (p_cap_a) else $error("masked bit changed in reg a");

	property p_cap_b;
		@(posedge clk) disable iff (rst)
			(doWrite && paddr == OFF_SOFT_RESET_B && capabilityMaskB[12] == 1'b0)
			|=> softResetB_ff[12] == $past(softResetB_ff[12]);
	endproperty
	a_cap_b: assert property (p_cap_b) else $error("masked bit changed in reg b");

	property p_port_rst;
		@(posedge clk) disable iff (rst)
			1'b1 |=> resetBus.portRst == $past(softResetC_ff[NUM_PORTS-1:0]);
	endproperty
	a_port_rst: assert property (p_port_rst) else $error("port reset mismatch");

	property p_periph_rst;
		@(posedge clk) disable iff (rst)
			1'b1 |=> resetBus.periphRst[12:11] ==
			{$past(softResetA_ff[16]), $past(softResetA_ff[3])};
	endproperty
	a_periph_rst: assert property (p_periph_rst) else $error("reg a reset mismatch");

	property p_uart_rst;
		@(posedge clk) disable iff (rst)
			1'b1 |=> resetBus.periphRst[5:4] == $past(softResetB_ff[1:0]);
	endproperty
	a_uart_rst: assert property (p_uart_rst) else $error("serial reset mismatch");

	property p_irq_level;
		@(posedge clk) disable iff (rst)
			1'b1 |=> irq == |($past(irqStatus_ff) & $past(irqMask_ff));
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq level mismatch");

	// Status bit only leaves on a write of one
	property p_sticky;
		@(posedge clk) disable iff (rst)
			irqStatus_ff[0] && !(doWrite && paddr == OFF_IRQ_STATUS && pwdata[0])
			|=> irqStatus_ff[0];
	endproperty
	a_sticky: assert property (p_sticky) else $error("status bit lost");

	property p_rst_outputs;
		@(posedge clk) disable iff (rst)
			$past(rst) |-> !pready && !irq && resetBus == '0 && !periphFault;
	endproperty
	a_rst_outputs: assert property (p_rst_outputs) else $error("outputs not idle after reset");

	c_write_c: cover property (@(posedge clk) disable iff (rst)
		doWrite && paddr == OFF_SOFT_RESET_C);
	c_fault: cover property (@(posedge clk) disable iff (rst) periphFault ##1 irq);
	c_deep: cover property (@(posedge clk) disable iff (rst) deepSleep ##1 !deepSleep);
	c_unmapped: cover property (@(posedge clk) disable iff (rst) pslverr);

endmodule

// ### tb.sv
// Self-checking bench for the peripheral reset and gating block
`timescale 1ns/10ps
module tb;
	import prg_pkg::*;
	localparam logic [11:0] OFFS [3] = '{OFF_SOFT_RESET_A, OFF_SOFT_RESET_B, OFF_SOFT_RESET_C};
	localparam logic [31:0] FLD [3]  = '{SOFT_A_FIELDS, SOFT_B_FIELDS, SOFT_C_FIELDS};
	logic                 clk, rst, psel, penable, pwrite, deepSleep;
	logic                 pready, pslverr, periphFault, irq;
	logic [ADDR_W-1:0]    paddr;
	logic [31:0]          pwdata, prdata, mA, mB, mD, seed;
	logic [31:0]          m [3];
	logic [NUM_PORTS-1:0] portClockEn;
	periph_req_t          periphReq;
	reset_bus_t           resetBus;
	logic [33:0]          expQ [$];
	logic [33:0]          e;
	int                   num_errors, cmp_count, cycles;

	peripheral_reset_and_gating dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .capabilityMaskA(mA), .capabilityMaskB(mB), .capabilityMaskD(mD),
		.deepSleep(deepSleep), .periphReq(periphReq), .periphFault(periphFault),
		.portClockEn(portClockEn), .resetBus(resetBus), .irq(irq));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task check(input logic [33:0] seen, input logic [33:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task conclude;
		$display("compares=%0d mismatches=%0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Result noted first, monitor compares it at pready
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] x, input logic err);
		expQ.push_back({wr, err, x});
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task poke(input logic [3:0] t, input logic f);
		@(posedge clk);
		periphReq <= '{valid: 1'b1, target: t};
		@(posedge clk);
		periphReq <= '0;
		#1 check(34'(periphFault), 34'(f));
	endtask

	// Waits only; the caller samples the output once it has settled
	task settle;
		repeat (2) @(posedge clk);
		#1;
	endtask

	function automatic reset_bus_t rb(input logic [31:0] a, input logic [31:0] b,
		input logic [31:0] c);
		rb = {a[16], a[3], b[18:16], b[12], b[4], b[1], b[0], 4'h0, c[4:0]};
	endfunction

	always @(posedge clk) begin
		if (pready === 1'b1) begin
			e = expQ.pop_front();
			check({e[33], pslverr, e[33] ? 32'h0 : prdata}, e);
		end
	end

	// Hang guard, generous for about 120 cycles of traffic
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			conclude();
		end
	end

	initial begin
		seed = 32'h9F66;
		{rst, psel, penable, pwrite, deepSleep} = 5'h10;
		{paddr, pwdata, periphReq} = '0;
		{mA, mB, mD} = {96{1'b1}};
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 3; i++) apb(1'b0, OFFS[i], 32'h0, SOFT_RESET_RST, 1'b0);
		apb(1'b0, OFF_DEEP_GATE, 32'h0, GATE_RST, 1'b0);
		check(34'(resetBus), 34'h0);
		$display("reset values done");
		for (int i = 0; i < 3; i++) apb(1'b1, OFFS[i], 32'hFFFF_FFFF, 32'h0, 1'b0);
		for (int i = 0; i < 3; i++) apb(1'b0, OFFS[i], 32'h0, FLD[i], 1'b0);
		check(34'(resetBus), 34'(rb(FLD[0], FLD[1], FLD[2])));
		for (int i = 0; i < 3; i++) m[i] = $random(seed);
		mA <= m[0];
		mB <= m[1];
		mD <= m[2];
		for (int i = 0; i < 3; i++) apb(1'b1, OFFS[i], 32'h0, 32'h0, 1'b0);
		for (int i = 0; i < 3; i++) apb(1'b0, OFFS[i], 32'h0, FLD[i] & ~m[i], 1'b0);
		check(34'(resetBus), 34'(rb(FLD[0] & ~m[0], FLD[1] & ~m[1], FLD[2] & ~m[2])));
		$display("reset fields done");
		apb(1'b1, OFF_DEEP_GATE, 32'hFFFF_FFE5, 32'h0, 1'b0);
		apb(1'b0, OFF_DEEP_GATE, 32'h0, 32'h5, 1'b0);
		deepSleep <= 1'b1;
		settle();
		check(34'(portClockEn), 34'h05);
		poke(4'h1, 1'b1);
		poke(4'h0, 1'b0);
		deepSleep <= 1'b0;
		settle();
		check(34'(portClockEn), 34'h1F);
		poke(4'h1, 1'b0);
		$display("clock gating done");
		// Interrupt raise, mask, clear
		apb(1'b0, OFF_IRQ_STATUS, 32'h0, 32'h3, 1'b0);
		check(34'(irq), 34'h0);
		apb(1'b1, OFF_IRQ_MASK, 32'h1, 32'h0, 1'b0);
		settle();
		check(34'(irq), 34'h1);
		apb(1'b1, OFF_IRQ_STATUS, 32'h3, 32'h0, 1'b0);
		settle();
		check(34'(irq), 34'h0);
		apb(1'b0, OFF_IRQ_STATUS, 32'h0, 32'h0, 1'b0);
		apb(1'b0, 12'h100, 32'h0, 32'h0, 1'b1);
		$display("interrupt and bus error done");
		conclude();
	end
endmodule
